// >>> rtl/sbg_pkg.sv
// Constants, register map and state codes of the serial break generator
package sbg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry
  localparam int          ADDR_W            = 3;
  localparam int          DATA_W            = 8;
  localparam int          LEN_W             = 4;
  localparam int          DIV_W             = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [2:0]  STATUS_OFS        = 3'h0;
  localparam logic [2:0]  BIT_DIV_OFS       = 3'h1;
  localparam logic [2:0]  CTRL_ONE_OFS      = 3'h2;
  localparam logic [2:0]  CTRL_TWO_OFS      = 3'h3;
  localparam logic [2:0]  CTRL_THREE_OFS    = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int          WORD_LEN_POS      = 4;  // serial_control_one
  localparam int          SEND_BREAK_POS    = 0;  // serial_control_two
  localparam int          TX_EN_POS         = 3;  // serial_control_two
  localparam int          LIN_SEL_POS       = 6;  // serial_control_three
  localparam int          ST_BUSY_POS       = 0;
  localparam int          ST_BREAK_POS      = 1;
  localparam int          ST_IDLE_POS       = 2;
  localparam int          ST_PEND_BRK_POS   = 3;
  localparam int          ST_PEND_IDLE_POS  = 4;
  localparam int          ST_LIN_POS        = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  CTRL_RST          = 8'h00;
  localparam logic [7:0]  BIT_DIV_RST       = 8'h0F;

  ////////////////////////////////////////////////////////////////////////////
  // Character lengths in bit times
  localparam logic [3:0]  BREAK_BITS_SHORT  = 4'hA;  // 10 bits
  localparam logic [3:0]  BREAK_BITS_LONG   = 4'hB;  // 11 bits
  localparam logic [3:0]  BREAK_BITS_LIN    = 4'hD;  // 13 bits
  localparam logic [3:0]  IDLE_BITS_SHORT   = 4'hA;  // 10 bits
  localparam logic [3:0]  IDLE_BITS_LONG    = 4'hB;  // 11 bits

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter states
  typedef enum logic [2:0] {
    SBG_READY     = 3'b001,
    SBG_IDLE_CHAR = 3'b010,
    SBG_BREAK     = 3'b100
  } sbg_state_t;

endpackage

// >>> rtl/sbg_bit_timer.sv
// Bit-time tick generator with restart for character alignment
`timescale 1ns/1ps
module sbg_bit_timer #(
  parameter int DIV_W = 8
) (
  // Clock, reset, enable
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             ce_i,
  // Control
  input  wire logic             restart_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  // Tick, one cycle per bit time
  output logic                  tick_o
);

  if (DIV_W < 1) begin : g_chk
    $error("sbg_bit_timer: DIV_W must be at least 1");
  end

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;

  // One bit time is divisor+1 clocks; restart realigns to a character start.
  // The tick ignores restart: the sequencer restarts on a tick, so gating it would close a loop
  always_comb begin
    tick_o   = ce_i && (cnt >= divisor_i);
    next_cnt = cnt;
    if (restart_i) begin
      next_cnt = '0;
    end else if (cnt >= divisor_i) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  // Counter register
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cnt <= '0;
    end else if (ce_i) begin
      cnt <= next_cnt;
    end
  end

endmodule

// >>> rtl/sbg_break_gen.sv
// Break and idle character generator of a serial transmitter with LIN master mode
//
// Notes on behaviour
// - Setting then clearing send_break_bit before the break ends sends exactly one break character.
// - Normal mode break lasts 10 bit times, or 11 with word length set.
// - While send_break_bit stays set, breaks follow one another back to back.
// - LIN master mode when LIN select is set and word length is clear.
// - In LIN master mode every requested break lasts 13 bit times.
// - Toggling tx_enable_bit queues an idle; a following break comes right after it.
// - Idle character ahead of a LIN break lasts 10 bit times.
`timescale 1ns/1ps
module sbg_break_gen
  #(
  parameter int DIV_W = sbg_pkg::DIV_W
) (
  // Clock, reset, enable
  input  wire logic                        clock_i,
  input  wire logic                        nrst_i,
  input  wire logic                        ce_i,
  // Register port
  input  wire logic [sbg_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [sbg_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [sbg_pkg::DATA_W-1:0]  rdata_o,
  // Serial line
  output logic                             tx_o
);
  import sbg_pkg::*;

  if (DIV_W != DATA_W) begin : g_chk
    $error("sbg_break_gen: DIV_W must equal the register data width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [DATA_W-1:0] ctrl_one;
  logic [DATA_W-1:0] ctrl_two;
  logic [DATA_W-1:0] ctrl_three;
  logic [DIV_W-1:0]  bit_div;
  logic [DATA_W-1:0] next_ctrl_one;
  logic [DATA_W-1:0] next_ctrl_two;
  logic [DATA_W-1:0] next_ctrl_three;
  logic [DIV_W-1:0]  next_bit_div;

  logic              pend_break;
  logic              pend_idle;
  logic              next_pend_break;
  logic              next_pend_idle;

  sbg_state_t        state;
  sbg_state_t        next_state;
  logic [LEN_W-1:0]  char_len;
  logic [LEN_W-1:0]  next_char_len;
  logic [LEN_W-1:0]  bit_cnt;
  logic [LEN_W-1:0]  next_bit_cnt;
  logic              next_tx;
  logic [DATA_W-1:0] next_rdata;

  logic              wr_ctrl_two;
  logic              break_req_rise;
  logic              tx_en_rise;
  logic              word_long;
  logic              tx_en;
  logic              break_held;
  logic              lin_master;
  logic [LEN_W-1:0]  break_len;
  logic [LEN_W-1:0]  idle_len;
  logic              tick;
  logic              char_end;
  logic              start_char;
  logic              take_break;
  logic              take_idle;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  // Control bits as they stand now
  assign word_long  = ctrl_one[WORD_LEN_POS];
  assign tx_en      = ctrl_two[TX_EN_POS];
  assign break_held = ctrl_two[SEND_BREAK_POS];
  assign lin_master = ctrl_three[LIN_SEL_POS] && !word_long;

  // Break length by mode
  always_comb begin
    if (lin_master) begin
      break_len = BREAK_BITS_LIN;
    end else if (word_long) begin
      break_len = BREAK_BITS_LONG;
    end else begin
      break_len = BREAK_BITS_SHORT;
    end
  end

  // idle is one 10-bit character in LIN mode
  assign idle_len = word_long ? IDLE_BITS_LONG : IDLE_BITS_SHORT;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  assign wr_ctrl_two    = wr_i && (addr_i == CTRL_TWO_OFS);
  // only a set edge of the request bit queues a break
  assign break_req_rise = wr_ctrl_two && wdata_i[SEND_BREAK_POS] && !break_held;
  // a set edge of the enable queues an idle character
  assign tx_en_rise     = wr_ctrl_two && wdata_i[TX_EN_POS] && !tx_en;

  // Next values of the software registers
  always_comb begin
    next_ctrl_one   = ctrl_one;
    next_ctrl_two   = ctrl_two;
    next_ctrl_three = ctrl_three;
    next_bit_div    = bit_div;
    if (wr_i) begin
      case (addr_i)
        BIT_DIV_OFS: begin
          next_bit_div = wdata_i;
        end
        CTRL_ONE_OFS: begin
          next_ctrl_one = wdata_i;
        end
        CTRL_TWO_OFS: begin
          next_ctrl_two = wdata_i;
        end
        CTRL_THREE_OFS: begin
          next_ctrl_three = wdata_i;
        end
        default: begin
          next_bit_div = bit_div;  // Status and unmapped writes ignored
        end
      endcase
    end
  end

  // Software register storage
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ctrl_one   <= CTRL_RST;
      ctrl_two   <= CTRL_RST;
      ctrl_three <= CTRL_RST;
      bit_div    <= BIT_DIV_RST;
    end else if (ce_i) begin
      ctrl_one   <= next_ctrl_one;
      ctrl_two   <= next_ctrl_two;
      ctrl_three <= next_ctrl_three;
      bit_div    <= next_bit_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing

  // Restarting at each character start keeps every duration exact,
  // which is what keeps the first bit of a character started from ready a full bit time
  sbg_bit_timer #(
    .DIV_W     (DIV_W)
  ) u_timer (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .restart_i (start_char),
    .divisor_i (bit_div),
    .tick_o    (tick)
  );

  assign char_end = tick && (bit_cnt == char_len - 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // Character sequencer

  // Pick the next character; from ready a queued idle goes ahead of a queued break, at a character end the break goes first
  always_comb begin
    next_state    = state;
    next_char_len = char_len;
    next_bit_cnt  = bit_cnt;
    take_break    = 1'b0;
    take_idle     = 1'b0;
    start_char    = 1'b0;
    case (state)
      SBG_READY: begin
        if (tx_en && pend_idle) begin
          take_idle = 1'b1;
        end else if (tx_en && pend_break) begin
          take_break = 1'b1;
        end
      end
      SBG_IDLE_CHAR: begin
        if (char_end) begin
          // break starts on the very edge the idle ends
          if (tx_en && pend_break) begin
            take_break = 1'b1;
          end else if (tx_en && pend_idle) begin
            take_idle = 1'b1;
          end else begin
            next_state = SBG_READY;
          end
        end
      end
      SBG_BREAK: begin
        if (char_end) begin
          // held request chains breaks with no gap
          if (tx_en && (break_held || pend_break)) begin
            take_break = 1'b1;
          end else if (tx_en && pend_idle) begin
            take_idle = 1'b1;
          end else begin
            next_state = SBG_READY;
          end
        end
      end
      default: begin
        next_state = SBG_READY;
      end
    endcase
    if (take_break) begin
      next_state    = SBG_BREAK;
      next_char_len = break_len;
      start_char    = 1'b1;
    end else if (take_idle) begin
      next_state    = SBG_IDLE_CHAR;
      next_char_len = idle_len;
      start_char    = 1'b1;
    end
    // Bit counter runs within a character only
    if (start_char) begin
      next_bit_cnt = '0;
    end else if (tick && (state != SBG_READY)) begin
      next_bit_cnt = bit_cnt + 1'b1;
    end
  end

  // Request flags: a new request in the consuming cycle is kept
  always_comb begin
    // one queued break per set edge
    next_pend_break = (pend_break && !take_break) || break_req_rise;
    next_pend_idle  = (pend_idle && !take_idle) || tx_en_rise;
  end

  // line low exactly while a break character runs
  assign next_tx = (next_state != SBG_BREAK);

  // Sequencer registers
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state      <= SBG_READY;
      char_len   <= BREAK_BITS_SHORT;
      bit_cnt    <= '0;
      pend_break <= 1'b0;
      pend_idle  <= 1'b0;
      tx_o       <= 1'b1;
    end else if (ce_i) begin
      state      <= next_state;
      char_len   <= next_char_len;
      bit_cnt    <= next_bit_cnt;
      pend_break <= next_pend_break;
      pend_idle  <= next_pend_idle;
      tx_o       <= next_tx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Read data valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = '0;
    if (rd_i) begin
      case (addr_i)
        STATUS_OFS: begin
          next_rdata[ST_BUSY_POS]      = (state != SBG_READY);
          next_rdata[ST_BREAK_POS]     = (state == SBG_BREAK);
          next_rdata[ST_IDLE_POS]      = (state == SBG_IDLE_CHAR);
          next_rdata[ST_PEND_BRK_POS]  = pend_break;
          next_rdata[ST_PEND_IDLE_POS] = pend_idle;
          next_rdata[ST_LIN_POS]       = lin_master;
        end
        BIT_DIV_OFS: begin
          next_rdata = bit_div;
        end
        CTRL_ONE_OFS: begin
          next_rdata = ctrl_one;
        end
        CTRL_TWO_OFS: begin
          next_rdata = ctrl_two;
        end
        CTRL_THREE_OFS: begin
          next_rdata = ctrl_three;
        end
        default: begin
          next_rdata = '0;  // Unmapped reads as zero
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= next_rdata;
    end
  end

endmodule

// >>> dv/sbg_break_gen_sva.sv
// Port checker of the serial break generator
`timescale 1ns/1ps
module sbg_break_sva (
  // Clock and reset
  input wire logic                       clock_i,
  input wire logic                       nrst_i,
  input wire logic                       ce_i,
  // Register port
  input wire logic [sbg_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sbg_pkg::DATA_W-1:0] wdata_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [sbg_pkg::DATA_W-1:0] rdata_o,
  // Serial line
  input wire logic                       tx_o
);
  import sbg_pkg::*;
  logic [7:0]  div, c1, c2, c3;
  logic [15:0] low_cnt, brk_len, pos;
  logic        lin, wr_c2;
  assign lin   = c3[LIN_SEL_POS] && !c1[WORD_LEN_POS];
  assign pos   = low_cnt % brk_len;
  assign wr_c2 = wr_i && addr_i == CTRL_TWO_OFS;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow registers; length taken while the line idles, since a mode change mid-break must not count
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      div     <= BIT_DIV_RST;
      c1      <= CTRL_RST;
      c2      <= CTRL_RST;
      c3      <= CTRL_RST;
      low_cnt <= 16'h0000;
      brk_len <= 16'h0001;
    end else if (ce_i) begin
      if (wr_i && addr_i == BIT_DIV_OFS) div <= wdata_i;
      if (wr_i && addr_i == CTRL_ONE_OFS) c1 <= wdata_i;
      if (wr_c2) c2 <= wdata_i;
      if (wr_i && addr_i == CTRL_THREE_OFS) c3 <= wdata_i;
      low_cnt <= tx_o ? 16'h0000 : low_cnt + 16'h0001;
      if (tx_o) brk_len <= (lin ? 16'h000D : c1[WORD_LEN_POS] ? 16'h000B : 16'h000A) * (16'h0001 + 16'(div));
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (@(posedge clock_i) !nrst_i |=> tx_o && rdata_o == 8'h00)
    else $error("line or read data busy after reset");
  a_rdata_zero: assert property (@(posedge clock_i) disable iff (!nrst_i) ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data without a read");
  a_unmapped_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_i && addr_i > CTRL_THREE_OFS |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  a_lin_status: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_i && addr_i == STATUS_OFS |=> rdata_o[ST_LIN_POS] == $past(lin)) else $error("LIN status wrong");
  a_break_flag: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_i && addr_i == STATUS_OFS && !tx_o |=> rdata_o[ST_BREAK_POS]) else $error("break flag low in break");
  a_break_len: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(tx_o) |-> low_cnt != 16'h0000 && pos == 16'h0000) else $error("break length wrong");
  a_break_stop: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !tx_o && !c2[SEND_BREAK_POS] && pos == brk_len - 16'h0001 |=> tx_o) else $error("extra break sent");
  a_break_repeat: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !tx_o && c2[SEND_BREAK_POS] && pos == brk_len - 16'h0001 |=> !tx_o) else $error("repeat break missing");
  a_enable_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !c2[TX_EN_POS] && !wr_c2 && tx_o |=> tx_o) else $error("break while disabled");
endmodule

bind sbg_break_gen sbg_break_sva u_sva (
  .clock_i (clock_i),
  .nrst_i  (nrst_i),
  .ce_i    (ce_i),
  .addr_i  (addr_i),
  .wdata_i (wdata_i),
  .wr_i    (wr_i),
  .rd_i    (rd_i),
  .rdata_o (rdata_o),
  .tx_o    (tx_o)
);

// >>> dv/sbg_peer_node.sv
// Peer node model that times the low runs on the serial line
`timescale 1ns/1ps
module sbg_peer_node (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // Serial line
  input  wire logic        rx_i,
  // Measurements
  output logic      [15:0] low_len_o,
  output logic      [15:0] t_fall_o,
  output logic      [15:0] t_now_o,
  output logic      [15:0] n_brk_o
);
  logic [15:0] run;
  ////////////////////////////////////////////////////////////////////////////
  // Every low run counts as one break; back to back breaks merge into one run
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      run       <= 16'h0000;
      low_len_o <= 16'h0000;
      t_fall_o  <= 16'h0000;
      t_now_o   <= 16'h0000;
      n_brk_o   <= 16'h0000;
    end else begin
      t_now_o <= t_now_o + 16'h0001;
      if (!rx_i) begin
        run <= run + 16'h0001;
        if (run == 16'h0000) t_fall_o <= t_now_o;
      end else if (run != 16'h0000) begin
        low_len_o <= run;
        n_brk_o   <= n_brk_o + 16'h0001;
        run       <= 16'h0000;
      end
    end
  end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench of the serial break generator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
  $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  import sbg_pkg::*;
  logic              clock_i = 1'b0;
  logic              nrst_i  = 1'b0;
  logic [ADDR_W-1:0] addr_i  = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic              wr_i    = 1'b0;
  logic              rd_i    = 1'b0;
  logic              ce_i    = 1'b1;
  logic [DATA_W-1:0] rdata_o, d;
  logic              tx_o;
  logic [15:0]       low_len, t_fall, t_now, n_brk, nb, t0, lat, b0;
  int                err_total = 0;
  int                n_tests   = 0;

  always #12.5 clock_i = ~clock_i;

  sbg_break_gen DUT (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_o(tx_o));
  sbg_peer_node PEER (.clock_i(clock_i), .nrst_i(nrst_i), .rx_i(tx_o), .low_len_o(low_len),
    .t_fall_o(t_fall), .t_now_o(t_now), .n_brk_o(n_brk));
  ////////////////////////////////////////////////////////////////////////////
  // Register port cycles; a write strobe stays up until a later rd or idle call lowers it, a read lowers its own strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    rd_i    <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    addr_i <= a;
    rd_i   <= 1'b1;
    wr_i   <= 1'b0;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge clock_i);
  endtask
  task automatic idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wait_brk(input logic [15:0] k);
    for (int i = 0; i < 2000 && n_brk !== k; i++) begin
      @(posedge clock_i);
      #1;
    end
    `CHK("break_seen", k, n_brk)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Set then clear the send bit after hold cycles; two clocks per bit time
  task automatic brk(input int bits, input int hold, input int reps);
    nb = n_brk + 16'h0001;
    wr(CTRL_TWO_OFS, 8'h09);
    idle(1);
    // Line falls on the edge after the write; t0 is taken just after that edge
    #1 t0 = t_now;
    @(posedge clock_i);
    rd(STATUS_OFS, d);
    `CHK("in_break", 2'b11, d[ST_BREAK_POS:ST_BUSY_POS])
    idle(hold);
    wr(CTRL_TWO_OFS, 8'h08);
    idle(1);
    wait_brk(nb);
    lat = t_fall - t0;
    `CHK("break_start", 16'h0000, lat)
    `CHK("break_len", bits * reps * 2, low_len)
    idle(60);
    `CHK("break_count", nb, n_brk)
  endtask
  task automatic results();
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    results();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    `CHK("tx_idle", 1'b1, tx_o)
    rd(BIT_DIV_OFS, d);
    `CHK("div_reset", BIT_DIV_RST, d)
    rd(3'h5, d);
    rd(3'h7, d);
    `CHK("unmapped", 8'h00, d)
    // Clock enable low: the write is lost and every flop holds
    ce_i <= 1'b0;
    wr(BIT_DIV_OFS, 8'h03);
    idle(1);
    ce_i <= 1'b1;
    rd(BIT_DIV_OFS, d);
    `CHK("ce_freeze", BIT_DIV_RST, d)
    wr(BIT_DIV_OFS, 8'h01);
    wr(CTRL_TWO_OFS, 8'h08);
    idle(40);
    // Every mode: normal short, normal long, LIN, long word overriding LIN
    for (int m = 0; m < 4; m++) begin
      wr(CTRL_ONE_OFS, m[0] ? 8'h10 : 8'h00);
      wr(CTRL_THREE_OFS, m[1] ? 8'h40 : 8'h00);
      rd(STATUS_OFS, d);
      `CHK("lin_mode", m == 2, d[ST_LIN_POS])
      brk(m == 2 ? 13 : m[0] ? 11 : 10, 2, 1);
    end
    b0 = lat;
    // Send bit held over three long-word breaks
    brk(11, 55, 3);
    // Enable toggle then break request, back to back as software is told to do
    wr(CTRL_ONE_OFS, 8'h00);
    nb = n_brk + 16'h0001;
    wr(CTRL_TWO_OFS, 8'h00);
    idle(2);
    wr(CTRL_TWO_OFS, 8'h08);
    wr(CTRL_TWO_OFS, 8'h09);
    wr(CTRL_TWO_OFS, 8'h08);
    idle(1);
    // Idle of 10 bit times (20 cycles) began two cycles before t0
    #1 t0 = t_now;
    wait_brk(nb);
    `CHK("lin_after_idle", 16'h001A, low_len)
    `CHK("idle_gap", b0 + 16'h0014 - 16'h0002, t_fall - t0)
    idle(40);
    results();
  end
endmodule
